/* verilog/gpd_port.sv */
// Top of the eight-bit general purpose port, with APB register slave.
// Assumes pins already synchronous to pclk and peripherals on the same clock.
//
// The implementer's own choices: the register offsets and the APB slave port.
`default_nettype none
module gpd_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  input wire logic [7:0] psp_data_out,
  input wire logic psp_data_oe,
  output logic [7:0] psp_data_in,
  output logic psp_active,
  input wire logic [3:0] pwm_channels,
  input wire gpd_pkg::gpd_pwm_mode_t pwm_mode,
  input wire logic ccp_compare_out,
  output logic ccp_capture_in,
  output logic [3:0] comparator_inputs
);
  import gpd_pkg::*;

  // ==========================================================
  // Register state
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] lat_r, lat_nxt;
  logic [7:0] odir_r, odir_nxt;
  logic [7:0] alt_r, alt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] pin_read;
  logic [3:0] cmp_sel;
  logic [3:0] pwm_en;
  logic ccp_out_en;
  gpd_pin_drive_t drive;
  gpd_psp_drive_t psp_bus;
  gpd_ccp_drive_t ccp_bus;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFF_PIN_LEVELS) || (a == OFF_DIRECTION) || (a == OFF_OUTPUT_LATCH) ||
                (a == OFF_OTHER_DIR_CTRL) || (a == OFF_ALT_CTRL);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Merge the low byte lane of a write under its strobe; masked bits keep their value
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [7:0] mask,
                                       input logic [7:0] wdata, input logic strb);
    lane0 = strb ? ((wdata & mask) | (old & ~mask)) : old;
  endfunction

  // Read multiplexer; unmapped addresses read as zero
  function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a,
                                          input logic [7:0] pins,
                                          input logic [7:0] dir,
                                          input logic [7:0] lat,
                                          input logic [7:0] odir,
                                          input logic [7:0] alt);
    unique case (a)
      OFF_PIN_LEVELS: read_mux = pins;
      OFF_DIRECTION: read_mux = dir;
      OFF_OUTPUT_LATCH: read_mux = lat;
      OFF_OTHER_DIR_CTRL: read_mux = odir;
      OFF_ALT_CTRL: read_mux = alt;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Alternate function decode
  always_comb begin
    cmp_sel = alt_r[ALT_CMP_LSB +: 4];
    // Multi-output PWM takes the slave port away
    psp_active = odir_r[PSP_SEL_BIT] &&
                 !(pwm_mode == GPD_PWM_DUAL || pwm_mode == GPD_PWM_QUAD);
    pwm_en = 4'h0;
    if (alt_r[ALT_PWM_LSB]) begin
      unique case (pwm_mode)
        GPD_PWM_OFF: pwm_en = 4'h0;
        GPD_PWM_SINGLE: pwm_en = 4'h1;
        GPD_PWM_DUAL: pwm_en = 4'h3;
        GPD_PWM_QUAD: pwm_en = 4'hf;
      endcase
    end
    // PWM drives only pins whose direction bit is cleared
    pwm_en = pwm_en & ~dir_r[7:4];
    ccp_out_en = alt_r[ALT_CCP_OUT_BIT] && !dir_r[CCP_PIN];
  end

  assign psp_bus.data_out = psp_data_out;
  assign psp_bus.data_oe = psp_data_oe;
  assign ccp_bus.pwm = pwm_channels;
  assign ccp_bus.compare_out = ccp_compare_out;

  gpd_pin_mux u_mux (
    .direction(dir_r),
    .latch(lat_r),
    .psp_active(psp_active),
    .parallel_slave_port(psp_bus),
    .ccp(ccp_bus),
    .ccp_out_en(ccp_out_en),
    .pwm_en(pwm_en),
    .drive(drive)
  );

  assign pin_out = drive.o;
  assign pin_oe = drive.oe;

  // ==========================================================
  // Input paths
  always_comb begin
    pin_read = pin_in;
    // Analog-selected pins read low
    pin_read[3:0] = pin_in[3:0] & ~cmp_sel;
  end
  assign comparator_inputs = pin_in[3:0] & cmp_sel;
  assign psp_data_in = psp_active ? pin_in : 8'h00;
  // Capture input is seen only when the pin is an input
  assign ccp_capture_in = alt_r[ALT_CCP_IN_BIT] && dir_r[CCP_PIN] && pin_in[CCP_PIN];

  // ==========================================================
  // APB slave, zero wait states
  // Reads are captured at the setup edge so the access phase shows them from a flop
  // and pready can stay high; the price is that a pin read is one cycle old.
  assign addr_ok = is_mapped(paddr);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  // ==========================================================
  // Per-register write strobes
  // The pin-level address and the latch address both land in the latch
  logic wr_pins;
  logic wr_dir;
  logic wr_lat;
  logic wr_odir;
  logic wr_alt;
  logic [7:0] wbyte;
  logic wlane;

  assign wr_pins = wr_en && hit(paddr, OFF_PIN_LEVELS);
  assign wr_dir = wr_en && hit(paddr, OFF_DIRECTION);
  assign wr_lat = wr_en && hit(paddr, OFF_OUTPUT_LATCH);
  assign wr_odir = wr_en && hit(paddr, OFF_OTHER_DIR_CTRL);
  assign wr_alt = wr_en && hit(paddr, OFF_ALT_CTRL);
  assign wbyte = pwdata[7:0];
  assign wlane = pstrb[0];

  // ==========================================================
  // Direction register
  // Reset leaves every pin an input so nothing is driven before software asks
  always_comb begin
    dir_nxt = dir_r;
    if (wr_dir) begin
      dir_nxt = lane0(dir_r, 8'hff, wbyte, wlane);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= DIR_RESET;
    end else begin
      dir_r <= dir_nxt;
    end
  end

  // ==========================================================
  // Output latch
  // Writing the pin-level address never stores pin levels, only the written byte
  always_comb begin
    lat_nxt = lat_r;
    if (wr_pins) begin
      lat_nxt = lane0(lat_r, 8'hff, wbyte, wlane);
    end else if (wr_lat) begin
      lat_nxt = lane0(lat_r, 8'hff, wbyte, wlane);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_r <= LATCH_RESET;
    end else begin
      lat_r <= lat_nxt;
    end
  end

  // ==========================================================
  // Other-port direction control
  // Only the slave-port select, bit 5 and the three direction bits are writable
  always_comb begin
    odir_nxt = odir_r;
    if (wr_odir) begin
      odir_nxt = lane0(odir_r, OTHER_DIR_WMASK, wbyte, wlane);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odir_r <= OTHER_DIR_RESET;
    end else begin
      odir_r <= odir_nxt;
    end
  end

  // ==========================================================
  // Alternate function control
  // Reset selects analog on the low four pins, so they read low until released
  always_comb begin
    alt_nxt = alt_r;
    if (wr_alt) begin
      alt_nxt = lane0(alt_r, ALT_CTRL_WMASK, wbyte, wlane);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_r <= ALT_CTRL_RESET;
    end else begin
      alt_r <= alt_nxt;
    end
  end

  // ==========================================================
  // Read data
  // Held until the next read setup; bits 31:8 are always zero
  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_en) begin
      prdata_nxt = {24'h00_0000, read_mux(paddr, pin_read, dir_r, lat_r, odir_r, alt_r)};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // ==========================================================
  // Slave error
  // Decided at setup and shown only in the access phase that follows
  always_comb begin
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      pslverr_nxt = !is_mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= pslverr_nxt;
    end
  end
endmodule : gpd_port
`default_nettype wire

/* shared/gpd_pkg.sv */
// Package for the eight-bit general purpose port with alternate functions.
// Assumes an APB register bus with 32-bit data; pins are synchronous to pclk.
`default_nettype none
package gpd_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 12;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] OFF_PIN_LEVELS = 12'h000;
  localparam logic [11:0] OFF_DIRECTION = 12'h004;
  localparam logic [11:0] OFF_OUTPUT_LATCH = 12'h008;
  localparam logic [11:0] OFF_OTHER_DIR_CTRL = 12'h00c;
  localparam logic [11:0] OFF_ALT_CTRL = 12'h010;
  // ==========================================================
  // Reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] OTHER_DIR_RESET = 8'h07;
  localparam logic [7:0] ALT_CTRL_RESET = 8'h0f;
  // ==========================================================
  // Field positions
  localparam int unsigned PSP_SEL_BIT = 4;
  localparam logic [7:0] OTHER_DIR_WMASK = 8'h37;
  localparam int unsigned ALT_CMP_LSB = 0;
  localparam int unsigned ALT_CCP_OUT_BIT = 4;
  localparam int unsigned ALT_CCP_IN_BIT = 5;
  localparam int unsigned ALT_PWM_LSB = 6;
  localparam logic [7:0] ALT_CTRL_WMASK = 8'hff;
  localparam int unsigned CCP_PIN = 4;
  localparam int unsigned PWM_LSB_PIN = 4;
  // ==========================================================
  // Enhanced PWM output modes
  typedef enum logic [1:0] {
    GPD_PWM_OFF = 2'b00,
    GPD_PWM_SINGLE = 2'b01,
    GPD_PWM_DUAL = 2'b10,
    GPD_PWM_QUAD = 2'b11
  } gpd_pwm_mode_t;
  // ==========================================================
  // Signal bundles
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } gpd_pin_drive_t;
  typedef struct packed {
    logic [7:0] data_out;
    logic data_oe;
  } gpd_psp_drive_t;
  typedef struct packed {
    logic [3:0] pwm;
    logic compare_out;
  } gpd_ccp_drive_t;
endpackage : gpd_pkg
`default_nettype wire

/* verilog/gpd_pin_mux.sv */
// Per-pin output mux of the port: latch, parallel slave port, capture/compare, PWM.
// Assumes control values come from registers of the top module, apart from its pwm_mode input that gates psp_active and pwm_en.
`default_nettype none
module gpd_pin_mux (
  input wire logic [7:0] direction,
  input wire logic [7:0] latch,
  input wire logic psp_active,
  input wire gpd_pkg::gpd_psp_drive_t parallel_slave_port,
  input wire gpd_pkg::gpd_ccp_drive_t ccp,
  input wire logic ccp_out_en,
  input wire logic [3:0] pwm_en,
  output gpd_pkg::gpd_pin_drive_t drive
);
  import gpd_pkg::*;
  // ==========================================================
  // Output drive selection
  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_pin
      logic o_v;
      logic oe_v;
      always_comb begin
        o_v = latch[i];
        oe_v = ~direction[i];
        if (i == CCP_PIN && ccp_out_en) begin
          o_v = ccp.compare_out;
        end
        // The low two index bits name the channel on pins four to seven
        if (i >= PWM_LSB_PIN && pwm_en[2'(i)]) begin
          o_v = ccp.pwm[2'(i)];
        end
        if (psp_active) begin
          // Parallel slave port ignores direction bits entirely
          o_v = parallel_slave_port.data_out[i];
          oe_v = parallel_slave_port.data_oe;
        end
      end
      assign drive.o[i] = o_v;
      assign drive.oe[i] = oe_v;
    end
  endgenerate
endmodule : gpd_pin_mux
`default_nettype wire

/* test/gpd_pins_model.sv */
// External pin model: resolves each pin from the port and an outside driver.
// Assumes the outside driver holds ext_val on every pin the port does not drive.
`default_nettype none
module gpd_pins_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Wire level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule // gpd_pins_model
`default_nettype wire

/* test/gpd_port_chk.sv */
// Port checker, bound to gpd_port.
// Assumes pclk and active-low presetn of the port.
`default_nettype none
module gpd_port_chk
  import gpd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] psp_data_out,
  input wire logic psp_data_oe,
  input wire logic [7:0] psp_data_in,
  input wire logic psp_active,
  input wire gpd_pkg::gpd_pwm_mode_t pwm_mode,
  input wire logic ccp_capture_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_dir;
  assign wr_dir = psel && penable && pwrite && pstrb[0] && paddr == OFF_DIRECTION;
  a_dir_sets_oe: assert property (wr_dir && !psp_active ##1 !psp_active |->
    pin_oe == ~$past(pwdata[7:0])) else $error("drivers do not follow direction");
  a_reset_inputs: assert property ($rose(presetn) |-> pin_oe == 8'h00)
    else $error("driver on after reset");
  a_psp_oe_all: assert property (psp_active |-> pin_oe == {8{psp_data_oe}})
    else $error("slave port does not own drivers");
  a_psp_data_out: assert property (psp_active && psp_data_oe |-> pin_out == psp_data_out)
    else $error("slave port data not on pins");
  a_psp_data_in: assert property (psp_data_in == (psp_active ? pin_in : 8'h00))
    else $error("slave port input wrong");
  a_pwm_no_psp: assert property (pwm_mode inside {GPD_PWM_DUAL, GPD_PWM_QUAD} |-> !psp_active)
    else $error("slave port alive in multi pwm");
  a_capture_gate: assert property (ccp_capture_in && !psp_active |-> pin_in[4] && !pin_oe[4])
    else $error("capture input from driven pin");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  c_psp: cover property (psp_active && psp_data_oe);
  c_cap: cover property (ccp_capture_in);
  c_err: cover property (pslverr);
endmodule // gpd_port_chk
bind gpd_port gpd_port_chk u_gpd_port_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .pin_in(pin_in), .pin_oe(pin_oe), .pin_out(pin_out),
  .psp_data_out(psp_data_out), .psp_data_oe(psp_data_oe), .psp_data_in(psp_data_in),
  .psp_active(psp_active), .pwm_mode(pwm_mode), .ccp_capture_in(ccp_capture_in));
`default_nettype wire

/* test/tb_top.sv */
// Testbench for gpd_port: APB master tasks and one task per scenario.
// Assumes the pin model closes the pin loop.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gpd_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, psp_oe = 0, cmp_o = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, psp_act, cap;
  logic [7:0] pin_in, pin_out, pin_oe, ext_val = 8'h36, psp_o = 8'h00, psp_in;
  logic [3:0] pwm_ch = 4'h6, cmp_in;
  gpd_pwm_mode_t pwm_mode = GPD_PWM_OFF;
  int error_cnt = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  gpd_port u_gpd_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .psp_data_out(psp_o), .psp_data_oe(psp_oe), .psp_data_in(psp_in), .psp_active(psp_act),
    .pwm_channels(pwm_ch), .pwm_mode(pwm_mode), .ccp_compare_out(cmp_o),
    .ccp_capture_in(cap), .comparator_inputs(cmp_in));
  gpd_pins_model u_gpd_pins_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .pin_in(pin_in));
  // ====
  // Shared tasks
  task close_out;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits on pready; no fixed wait state count is assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 20) begin
      error_cnt++;
      close_out();
    end
    @(posedge pclk);
    #1;
  endtask
  // Drives peripheral-side inputs at a rising edge, then lets the pins settle
  task drive_side(input gpd_pwm_mode_t m, input logic oe, input logic [7:0] po,
                  input logic [7:0] ev);
    @(posedge pclk);
    pwm_mode <= m;
    psp_oe <= oe;
    psp_o <= po;
    ext_val <= ev;
    @(posedge pclk);
    #1;
  endtask
  // ====
  // Scenarios
  task s_reset;
    chk(pin_oe, 8'h00);
    apb(0, OFF_DIRECTION, 0); chk(rd, 32'hff);
    apb(0, OFF_OUTPUT_LATCH, 0); chk(rd, 32'h00);
    apb(0, OFF_OTHER_DIR_CTRL, 0); chk(rd, 32'h07);
  endtask
  task s_dir_latch;
    apb(1, OFF_OUTPUT_LATCH, 32'ha5); apb(1, OFF_DIRECTION, 32'h0f);
    chk(pin_oe, 8'hf0); chk(pin_out[7:4], 4'ha);
    apb(0, OFF_PIN_LEVELS, 0); chk(rd, 32'ha0);
    chk(cmp_in, 4'h6);
    apb(1, OFF_ALT_CTRL, 32'h00); apb(0, OFF_PIN_LEVELS, 0); chk(rd, 32'ha6);
    apb(0, OFF_OUTPUT_LATCH, 0); chk(rd, 32'ha5);
    apb(1, OFF_PIN_LEVELS, 32'h3c); apb(0, OFF_OUTPUT_LATCH, 0); chk(rd, 32'h3c);
  endtask
  task s_pwm_psp;
    apb(1, OFF_DIRECTION, 32'h00); apb(1, OFF_ALT_CTRL, 32'h40);
    drive_side(GPD_PWM_QUAD, 1'b0, 8'h00, 8'h36); chk(pin_out, 8'h6c);
    drive_side(GPD_PWM_SINGLE, 1'b0, 8'h00, 8'h36); chk(pin_out, 8'h2c);
    drive_side(GPD_PWM_DUAL, 1'b1, 8'h5a, 8'h36);
    apb(1, OFF_OTHER_DIR_CTRL, 32'h10); chk(psp_act, 1'b0);
    drive_side(GPD_PWM_OFF, 1'b1, 8'h5a, 8'h36); chk(pin_oe, 8'hff);
    chk(pin_out, 8'h5a);
    chk(psp_in, 8'h5a);
    apb(1, OFF_OTHER_DIR_CTRL, 32'h00); chk(psp_act, 1'b0);
  endtask
  task s_ccp_err;
    apb(1, OFF_ALT_CTRL, 32'h10); apb(1, OFF_DIRECTION, 32'hef);
    chk(pin_out[4], 1'b0);
    drive_side(GPD_PWM_OFF, 1'b1, 8'h5a, 8'h10);
    apb(1, OFF_ALT_CTRL, 32'h30); apb(1, OFF_DIRECTION, 32'hff);
    chk(cap, 1'b1);
    apb(1, 12'h020, 32'hff); chk(err, 1'b1);
    apb(0, 12'h020, 0); chk(rd, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    s_reset();
    s_dir_latch();
    s_pwm_psp();
    s_ccp_err();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
